/* hw/owf_top.sv */
// Output word formatter: config register plus 20-bit output word builder.
// Assumes the serial port decodes frames and presents a one-cycle write or
// read strobe, and pulses word_start before each word is shifted out.
//
// Summary of operation
// - Each conversion leaves as a 20-bit word shaped by the config register.
// - Config bits 7:6 are reserved, read zero, reset zero.
// - Span bits 5:4 choose 4, 8, 12 or 16 MSBs for partial parity.
// - Parity enable low forces word bits 1:0 to zero.
// - Parity enable high puts parity in word bits 1:0.
// - Word bit 1 is even parity of word bits 19:2.
// - Word bit 0 is even parity of the span-selected MSBs.
// - Pattern bits 2:0 drive word bits 19:2; codes 0xx pass the result.
// - Pattern 100 gives zeros, 101 ones, 110 gives 15555h.
// - Pattern 111 gives 03333h on the upper bits.
// - Span, enable and pattern fields are read/write and reset to zero.
`timescale 1ns/1ps
`default_nettype none
module owf_top (
  input wire logic clk, // 200 MHz clock
  input wire logic resetn, // Async reset, active low
  input wire owf_pkg::owf_reg_req_t reg_req, // Register write request
  input wire logic reg_rd, // Register read strobe
  input wire logic [11:0] reg_rd_addr, // Register read address
  output logic [7:0] reg_rdata, // Read data, valid after reg_rd
  output logic reg_rvalid, // Read data valid pulse
  input wire logic [17:0] conv_result, // Conversion result
  input wire logic conv_valid, // Result strobe, same clock
  input wire logic word_start, // Start of next word shift
  output logic [19:0] out_word, // Word being shifted out
  output logic out_word_valid // Pulse when word updated
);
  import owf_pkg::*;

  // ==========================================================
  // Config register
  owf_cfg_t cfg_q, cfg_d;
  owf_cfg_t act_q, act_d;
  logic [7:0] rdata_q, rdata_d;
  logic rvalid_q, rvalid_d;

  always_comb begin
    cfg_d = cfg_q;
    if (reg_req.wr && reg_req.addr == OWF_CFG_ADDR) begin
      cfg_d.partial_parity_span = reg_req.wdata[OWF_SPAN_LSB +: 2];
      cfg_d.parity_append_enable = reg_req.wdata[OWF_PARITY_APPEND_ENABLE_BIT];
      cfg_d.test_pattern_select = reg_req.wdata[OWF_PATN_LSB +: 3];
    end
    rvalid_d = reg_rd;
    rdata_d = rdata_q;
    if (reg_rd) begin
      // Unmapped addresses and reserved bits read as zero
      rdata_d = 8'h00;
      if (reg_rd_addr == OWF_CFG_ADDR) begin
        rdata_d = {2'h0, cfg_q};
      end
    end
    // Latch active config only at word boundaries so a word never mixes settings
    act_d = word_start ? cfg_q : act_q;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cfg_q <= owf_cfg_t'(OWF_CFG_RESET[5:0]);
      act_q <= owf_cfg_t'(OWF_CFG_RESET[5:0]);
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      cfg_q <= cfg_d;
      act_q <= act_d;
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  // ==========================================================
  // Word builder
  logic [17:0] result_q, result_d;
  logic [17:0] upper;
  logic full_par, part_par;
  logic [19:0] word_q, word_d;
  logic wvalid_q, wvalid_d;
  logic wvalid_pend_q, wvalid_pend_d;

  always_comb begin
    result_d = conv_valid ? conv_result : result_q;
    if (!act_q.test_pattern_select[2]) begin
      upper = result_q;
    end else begin
      unique case (owf_patn_t'(act_q.test_pattern_select))
        OWF_P_ZERO: upper = OWF_PATN_ZEROS;
        OWF_P_ONE: upper = OWF_PATN_ONES;
        OWF_P_ALT1: upper = OWF_PATN_ALT1;
        OWF_P_ALT2: upper = OWF_PATN_ALT2;
        default: upper = result_q;
      endcase
    end
  end

  owf_parity u_par (
    .upper(upper),
    .span(act_q.partial_parity_span),
    .full_par(full_par),
    .part_par(part_par)
  );

  always_comb begin
    word_d = word_q;
    wvalid_d = 1'b0;
    wvalid_pend_d = word_start;
    // Built one cycle after word_start, once the new config is active
    if (wvalid_pend_q) begin
      wvalid_d = 1'b1;
      if (act_q.parity_append_enable) begin
        word_d = {upper, full_par, part_par};
      end else begin
        word_d = {upper, 2'h0};
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      result_q <= 18'h00000;
      word_q <= 20'h00000;
      wvalid_q <= 1'b0;
      wvalid_pend_q <= 1'b0;
    end else begin
      result_q <= result_d;
      word_q <= word_d;
      wvalid_q <= wvalid_d;
      wvalid_pend_q <= wvalid_pend_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign reg_rvalid = rvalid_q;
  assign out_word = word_q;
  assign out_word_valid = wvalid_q;
endmodule
`default_nettype wire

/* hw/owf_pkg.sv */
// Package for the output word formatter: register map, field layout, patterns.
// Assumes a single 200 MHz clock domain shared by all users.
package owf_pkg;

  // ==========================================================
  // Register map
  localparam logic [11:0] OWF_CFG_ADDR = 12'h01c;
  localparam logic [7:0] OWF_CFG_RESET = 8'h00;
  localparam int OWF_SPAN_LSB = 4;
  localparam int OWF_PARITY_APPEND_ENABLE_BIT = 3;
  localparam int OWF_PATN_LSB = 0;

  // ==========================================================
  // Word layout
  localparam int OWF_WORD_W = 20;
  localparam int OWF_DATA_W = 18;
  localparam logic [17:0] OWF_PATN_ZEROS = 18'h00000;
  localparam logic [17:0] OWF_PATN_ONES = 18'h3ffff;
  localparam logic [17:0] OWF_PATN_ALT1 = 18'h15555;
  localparam logic [17:0] OWF_PATN_ALT2 = 18'h03333;

  typedef enum logic [2:0] {
    OWF_P_ZERO = 3'h4,
    OWF_P_ONE = 3'h5,
    OWF_P_ALT1 = 3'h6,
    OWF_P_ALT2 = 3'h7
  } owf_patn_t;

  typedef struct packed {
    logic [1:0] partial_parity_span;
    logic parity_append_enable;
    logic [2:0] test_pattern_select;
  } owf_cfg_t;

  typedef struct packed {
    logic [11:0] addr;
    logic [7:0] wdata;
    logic wr;
  } owf_reg_req_t;

endpackage

/* hw/owf_parity.sv */
// Parity stage: forms the two appended bits for an 18-bit upper field.
// Assumes inputs are stable registered values; purely combinational.
`timescale 1ns/1ps
`default_nettype none
module owf_parity (
  input wire logic [17:0] upper, // Upper 18 bits of the word
  input wire logic [1:0] span, // Partial span code
  output logic full_par, // Even parity of all 18 bits
  output logic part_par // Even parity over selected MSBs
);
  import owf_pkg::*;

  always_comb begin
    full_par = ^upper;
    unique case (span)
      2'h0: part_par = ^upper[17:14];
      2'h1: part_par = ^upper[17:10];
      2'h2: part_par = ^upper[17:6];
      2'h3: part_par = ^upper[17:2];
    endcase
  end
endmodule
`default_nettype wire

/* verif/owf_host_model.sv */
// Host model: keeps the last word read out.
// Assumes one clock shared with the device.
`timescale 1ns/1ps
`default_nettype none
module owf_host_model (
  input wire logic clk, // Clock
  input wire logic [19:0] out_word, // Word
  input wire logic out_word_valid, // Strobe
  output logic [19:0] last_word // Last word
);
  always_ff @(posedge clk) if (out_word_valid) last_word <= out_word;
endmodule
`default_nettype wire

/* verif/owf_props.sv */
// Checker on owf_top ports.
// Assumes one clock; the bind is at the foot.
`timescale 1ns/1ps
`default_nettype none
module owf_props (
  input wire logic clk, // Clock
  input wire logic resetn, // Reset
  input wire logic reg_rd, // Read
  input wire logic [7:0] reg_rdata, // Data
  input wire logic reg_rvalid, // Valid
  input wire logic word_start, // Start
  input wire logic [19:0] out_word, // Word
  input wire logic out_word_valid // Strobe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence lat_s; ##2 out_word_valid; endsequence
  rd_ans_a: assert property (reg_rd |=> reg_rvalid) else $error("no rvalid");
  rd_src_a: assert property (reg_rvalid |-> $past(reg_rd)) else $error("rvalid");
  rsvd_zero_a: assert property (reg_rvalid |-> !reg_rdata[7:6]) else $error("rsvd");
  word_lat_a: assert property (word_start |-> lat_s) else $error("late");
  word_src_a: assert property (out_word_valid |-> $past(word_start, 2))
    else $error("stray word");
  word_hold_a: assert property (!out_word_valid |-> $stable(out_word))
    else $error("word moved");
  full_par_a: assert property ((out_word[1] || out_word[0]) |->
    out_word[1] == ^out_word[19:2]) else $error("par");
  part_par_a: assert property (out_word[0] |-> ^out_word[19:16] || ^out_word[19:12]
    || ^out_word[19:8] || ^out_word[19:4]) else $error("part par");
endmodule
bind owf_top owf_props u_props (.*);
`default_nettype wire

/* verif/output_word_formatter_tb_top.sv */
// Bench: full config sweep against a word model.
// Assumes checker bind and host model are compiled.
`timescale 1ns/1ps
`default_nettype none
module output_word_formatter_tb_top;
  import owf_pkg::*;
  logic clk = 0, resetn = 0, reg_rd = 0, conv_valid = 0, word_start = 0;
  logic reg_rvalid, out_word_valid;
  owf_reg_req_t reg_req = '0;
  logic [11:0] reg_rd_addr = '0;
  logic [7:0] reg_rdata;
  logic [17:0] conv_result = '0;
  logic [19:0] out_word, last_word;
  int mismatches = 0, checks_done = 0, cycles = 0, r, u, n;
  int pats[4] = '{18'h0, 18'h3ffff, 18'h15555, 18'h3333};
  always #2.5 clk = ~clk;
  owf_top DUT (.*);
  owf_host_model host (.*);
  task end_of_test();
    $display("checks_done %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles > 2000) begin
      mismatches++;
      end_of_test();
    end
  end
  task cmp(input logic [19:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task wr(input logic [11:0] a, input logic [7:0] d);
    reg_req = '{a, d, 1'b1};
    @(negedge clk) reg_req.wr = 1'b0;
  endtask
  task rd(input logic [11:0] a, input logic [7:0] e);
    reg_rd = 1'b1;
    reg_rd_addr = a;
    @(negedge clk) reg_rd = 1'b0;
    cmp(20'({reg_rvalid, reg_rdata}), 20'({1'b1, e}));
  endtask
  function logic [19:0] model(int c, int v);
    u = c[2] ? pats[c[1:0]] : v;
    n = 4 * (((c >> 4) & 3) + 1);
    if (!c[3]) return {u[17:0], 2'h0};
    return {u[17:0], ^u[17:0], ^(u[17:0] >> (18 - n))};
  endfunction
  initial begin
    void'($urandom(34));
    repeat (8) @(negedge clk);
    resetn = 1'b1;
    rd(OWF_CFG_ADDR, 8'h00);
    wr(OWF_CFG_ADDR, 8'hff);
    rd(OWF_CFG_ADDR, 8'h3f);
    // Write to another address must leave the config alone
    wr(12'h018, 8'h15);
    rd(OWF_CFG_ADDR, 8'h3f);
    for (int k = 0; k < 64; k++) begin
      r = $urandom & 32'h3ffff;
      wr(OWF_CFG_ADDR, 8'(k));
      conv_result = 18'(r);
      conv_valid = 1'b1;
      @(negedge clk) conv_valid = 1'b0;
      word_start = 1'b1;
      @(negedge clk) word_start = 1'b0;
      // Late write must not touch the word in flight
      wr(OWF_CFG_ADDR, 8'($urandom));
      @(negedge clk) cmp(last_word, model(k, r));
    end
    // Second reset mid-run must bring the config back to its default
    resetn = 1'b0;
    repeat (2) @(negedge clk);
    resetn = 1'b1;
    rd(OWF_CFG_ADDR, 8'h00);
    end_of_test();
  end
endmodule
`default_nettype wire
